// ### design/tsr_readout.sv
// touch panel serial readout: serial frame logic, plate switching, pen interrupt
// Notes on behaviour
// - each measurement yields a 12-bit successive approximation result.
// - a location needs one X conversion and one Y conversion.
// - X measurement drives both X plates, senses Y plus, Y minus open.
// - Y measurement drives both Y plates, senses X plus, X minus open.
// - pressure drives Y plus and X minus; senses X plus then Y minus.
// - temperature, battery and aux measurements leave all four plates open.
// - pen waiting pulls X plus up, Y plus open, Y minus grounded.
// - reference pin is an output when the high power bit is one.
// - irq enabled and deselected: interrupt low while the pen is down.
// - irq disabled and deselected: interrupt held high.
// - result bits leave on falling serial clock edges.
// - msb appears at the falling edge of busy.
// - selected and idle, result output is driven low.
// - deselected, result and busy outputs are high impedance.
// - busy goes low as soon as the device is selected.
// - busy is high from the 8th to the 9th falling edge.
// - command bits are captured on rising serial clock edges.
// - serial input is ignored while deselected.
// - input is tracked for three serial clock periods before conversion.
// - results are straight binary, zero input all zeros.
// - a command with both power bits zero enters full power down.
`include "tsr_map.svh"

module tsr_readout #(
    parameter int CMD_BITS = `TSR_CMD_BITS,
    parameter int RES_BITS = `TSR_RESULT_BITS
) (
    // system clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    // serial link from the host
    input  wire logic               i_serial_clock,
    input  wire logic               i_chip_select_low,
    input  wire logic               i_serial_command_input,
    output logic                    o_serial_result_output,
    output logic                    o_serial_result_oe_low,
    output logic                    o_busy,
    output logic                    o_busy_oe_low,
    // converter front end
    input  wire logic               i_cmp_above,
    output logic [RES_BITS-1:0]     o_dac_code,
    output logic                    o_track,
    // panel plates
    input  wire logic               i_pen_down,
    output tsr_pkg::tsr_plate_t     o_x_plus_plate,
    output tsr_pkg::tsr_plate_t     o_y_plus_plate,
    output tsr_pkg::tsr_plate_t     o_x_minus_plate,
    output tsr_pkg::tsr_plate_t     o_y_minus_plate,
    // interrupt, reference and power
    output logic                    o_touch_interrupt_low,
    output logic                    o_ref_drive,
    output logic                    o_power_down
);
    import tsr_pkg::*;

    localparam logic [4:0] MSB_FALL = `TSR_MSB_FALL;
    localparam logic [4:0] LSB_FALL = 5'(`TSR_MSB_FALL + RES_BITS - 1);
    localparam logic [4:0] END_FALL = 5'(`TSR_MSB_FALL + RES_BITS);
    localparam logic [4:0] TRACK_END_FALL = 5'(`TSR_TRACK_FALL + `TSR_TRACK_PERIODS);

    // plates while waiting for a pen
    localparam tsr_panel_t PEN_WAIT = '{
        x_plus:  TSR_PLATE_PULLUP,
        y_plus:  TSR_PLATE_OPEN,
        x_minus: TSR_PLATE_OPEN,
        y_minus: TSR_PLATE_LOW
    };

    // plate setting for a measurement channel
    function automatic tsr_panel_t plates_for(input logic [2:0] ch);
        tsr_panel_t p;
        p = '{TSR_PLATE_OPEN, TSR_PLATE_OPEN, TSR_PLATE_OPEN, TSR_PLATE_OPEN};
        case (ch)
            `TSR_CH_X_AXIS: begin
                p.x_plus  = TSR_PLATE_HIGH;
                p.x_minus = TSR_PLATE_LOW;
                p.y_plus  = TSR_PLATE_SENSE;
            end
            `TSR_CH_Y_AXIS: begin
                p.y_plus  = TSR_PLATE_HIGH;
                p.y_minus = TSR_PLATE_LOW;
                p.x_plus  = TSR_PLATE_SENSE;
            end
            `TSR_CH_PRESS_FIRST: begin
                p.y_plus  = TSR_PLATE_HIGH;
                p.x_minus = TSR_PLATE_LOW;
                p.x_plus  = TSR_PLATE_SENSE;
            end
            `TSR_CH_PRESS_SECOND: begin
                p.y_plus  = TSR_PLATE_HIGH;
                p.x_minus = TSR_PLATE_LOW;
                p.y_minus = TSR_PLATE_SENSE;
            end
            default: begin
                p = p;
            end
        endcase
        return p;
    endfunction : plates_for

    // true on the falling edges that carry result bits
    function automatic logic in_result(input logic [4:0] cnt);
        return (cnt >= MSB_FALL) && (cnt <= LSB_FALL);
    endfunction : in_result

    // channel field once the first four command bits are in
    function automatic logic [2:0] early_channel(input logic [CMD_BITS-1:0] sh);
        return sh[2:0];
    endfunction : early_channel

    // link domain, reset asynchronously by deselection
    logic                rst_cs;
    logic [4:0]          rise_cnt_reg;
    logic [4:0]          fall_cnt_reg;
    logic [CMD_BITS-1:0] cmd_shift_reg;
    logic                cmd_done_reg;
    logic                cmp_reg;
    logic                busy_reg;
    logic                dout_reg;
    logic                track_reg;
    tsr_panel_t          panel_reg;

    // system domain
    logic                cs_meta_reg;
    logic                cs_sync_reg;
    logic                pen_meta_reg;
    logic                pen_sync_reg;
    logic                done_meta_reg;
    logic                done_sync_reg;
    logic                done_seen_reg;
    logic [1:0]          pd_reg;
    logic                irq_low_reg;
    logic                oe_low_reg;
    logic                power_down_reg;

    // deselection ends a frame even if the serial clock has already stopped
    assign rst_cs = i_chip_select_low;

    tsr_sar_if #(.W(RES_BITS)) sar_bus (
        .sclk   (i_serial_clock),
        .rst_cs (rst_cs)
    );

    assign sar_bus.fall_cnt = fall_cnt_reg;
    assign sar_bus.cmp_q    = cmp_reg;

    tsr_sar #(.W(RES_BITS)) u_sar (
        .sar (sar_bus)
    );

    // rising edge count, saturates so long frames stay harmless
    always_ff @(posedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            rise_cnt_reg <= 5'h00;
        end else if (rise_cnt_reg != 5'h1F) begin
            rise_cnt_reg <= rise_cnt_reg + 5'h01;
        end
    end

    // command bits, only the first eight rising edges of a frame
    always_ff @(posedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            cmd_shift_reg <= `TSR_CMD_RESET;
        end else if (rise_cnt_reg <= `TSR_LAST_CMD_RISE) begin
            cmd_shift_reg <= {cmd_shift_reg[CMD_BITS-2:0], i_serial_command_input};
        end
    end

    // completed command level; the word stays still until deselection
    always_ff @(posedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            cmd_done_reg <= 1'b0;
        end else if (rise_cnt_reg == `TSR_LAST_CMD_RISE) begin
            cmd_done_reg <= 1'b1;
        end
    end

    // latched comparator strobed on the rising edge, same clock domain
    always_ff @(posedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            cmp_reg <= 1'b0;
        end else begin
            cmp_reg <= i_cmp_above;
        end
    end

    // falling edge count
    always_ff @(negedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            fall_cnt_reg <= 5'h00;
        end else if (fall_cnt_reg != 5'h1F) begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
        end
    end

    // busy: low at selection, high for one period after the command
    always_ff @(negedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (fall_cnt_reg == `TSR_BUSY_FALL);
        end
    end

    // result bit decided on this edge goes straight out
    always_ff @(negedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            dout_reg <= 1'b0;
        end else if (in_result(fall_cnt_reg)) begin
            dout_reg <= cmp_reg;
        end else begin
            dout_reg <= 1'b0;
        end
    end

    // sample and hold window ends where busy rises
    always_ff @(negedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            track_reg <= 1'b0;
        end else if (fall_cnt_reg == `TSR_TRACK_FALL) begin
            track_reg <= 1'b1;
        end else if (fall_cnt_reg == TRACK_END_FALL) begin
            track_reg <= 1'b0;
        end
    end

    // plates switch once the channel bits are in, before tracking starts
    always_ff @(negedge i_serial_clock or posedge rst_cs) begin
        if (rst_cs) begin
            panel_reg <= PEN_WAIT;
        end else if (fall_cnt_reg == `TSR_PLATE_FALL) begin
            panel_reg <= plates_for(early_channel(cmd_shift_reg));
        end
    end

    assign o_busy                 = busy_reg;
    assign o_serial_result_output = dout_reg;
    assign o_track                = track_reg;
    assign o_dac_code             = sar_bus.code;
    assign o_x_plus_plate         = panel_reg.x_plus;
    assign o_y_plus_plate         = panel_reg.y_plus;
    assign o_x_minus_plate        = panel_reg.x_minus;
    assign o_y_minus_plate        = panel_reg.y_minus;

    // select synchroniser, idles deselected
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
        end else begin
            cs_meta_reg <= i_chip_select_low;
            cs_sync_reg <= cs_meta_reg;
        end
    end

    // pen detect synchroniser
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pen_meta_reg <= 1'b0;
            pen_sync_reg <= 1'b0;
        end else begin
            pen_meta_reg <= i_pen_down;
            pen_sync_reg <= pen_meta_reg;
        end
    end

    // command done synchroniser, from the link domain
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            done_meta_reg <= 1'b0;
            done_sync_reg <= 1'b0;
        end else begin
            done_meta_reg <= cmd_done_reg;
            done_sync_reg <= done_meta_reg;
        end
    end

    // power bits taken from the command word once its done level has crossed;
    // the word is still from done until deselection, so its bits cross as a group
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            done_seen_reg <= 1'b0;
            pd_reg        <= `TSR_PD_RESET;
        end else begin
            done_seen_reg <= done_sync_reg;
            if (done_sync_reg && !done_seen_reg) begin
                pd_reg <= cmd_shift_reg[`TSR_PD_HIGH_POS:`TSR_PD_LOW_POS];
            end
        end
    end

    // full power down follows the latest command
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            power_down_reg <= 1'b1;
        end else begin
            power_down_reg <= (pd_reg == 2'h0);
        end
    end

    // pen interrupt only reported while deselected, enabled by a zero low bit
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_low_reg <= 1'b1;
        end else if (cs_sync_reg && !pd_reg[`TSR_PD_LOW_POS]) begin
            irq_low_reg <= !pen_sync_reg;
        end else begin
            irq_low_reg <= 1'b1;
        end
    end

    // output enables follow synced select; three clocks stay inside the allowed delay
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            oe_low_reg <= 1'b1;
        end else begin
            oe_low_reg <= cs_sync_reg;
        end
    end

    // reference direction
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ref_drive <= 1'b0;
        end else begin
            o_ref_drive <= pd_reg[`TSR_PD_HIGH_POS];
        end
    end

    assign o_touch_interrupt_low  = irq_low_reg;
    assign o_serial_result_oe_low = oe_low_reg;
    assign o_busy_oe_low          = oe_low_reg;
    assign o_power_down           = power_down_reg;

endmodule : tsr_readout

// ### design/tsr_map.svh
// field positions, channel codes, reset values and timing counts of the touch panel readout
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH

// command word layout, first bit shifted in is the msb
`define TSR_CMD_BITS        8
`define TSR_RESULT_BITS     12
`define TSR_CH_MSB          6
`define TSR_CH_LSB          4
`define TSR_PD_HIGH_POS     1
`define TSR_PD_LOW_POS      0

// measurement channel codes
`define TSR_CH_TEMP0        3'h0
`define TSR_CH_Y_AXIS       3'h1
`define TSR_CH_BATTERY      3'h2
`define TSR_CH_PRESS_FIRST  3'h3
`define TSR_CH_PRESS_SECOND 3'h4
`define TSR_CH_X_AXIS       3'h5
`define TSR_CH_AUX          3'h6
`define TSR_CH_TEMP1        3'h7

// serial clock edge counts, value of the edge counter before the edge acts
`define TSR_LAST_CMD_RISE   5'h07
`define TSR_PLATE_FALL      5'h03
`define TSR_TRACK_FALL      5'h04
`define TSR_TRACK_PERIODS   3
`define TSR_BUSY_FALL       5'h07
`define TSR_MSB_FALL        5'h08

// reset values
`define TSR_PD_RESET        2'h0
`define TSR_CMD_RESET       8'h00

// timing figures
`define TSR_SYS_CLK_KHZ     25000
`define TSR_MAX_RATE_KHZ    125

`endif

// ### design/tsr_pkg.sv
// types shared by the touch panel readout modules
package tsr_pkg;

    // state of one panel plate pin
    typedef enum logic [2:0] {
        TSR_PLATE_OPEN,
        TSR_PLATE_HIGH,
        TSR_PLATE_LOW,
        TSR_PLATE_SENSE,
        TSR_PLATE_PULLUP
    } tsr_plate_t;

    // all four plates together
    typedef struct packed {
        tsr_plate_t x_plus;
        tsr_plate_t y_plus;
        tsr_plate_t x_minus;
        tsr_plate_t y_minus;
    } tsr_panel_t;

endpackage : tsr_pkg

// ### design/tsr_sar_if.sv
// link-side signals between the frame control and the approximation register
interface tsr_sar_if #(
    parameter int W = 12
) (
    input  logic sclk,
    input  logic rst_cs
);
    logic [4:0]   fall_cnt;
    logic         cmp_q;
    logic [W-1:0] code;

    modport ctrl (input sclk, input rst_cs, output fall_cnt, output cmp_q, input code);
    modport sar  (input sclk, input rst_cs, input fall_cnt, input cmp_q, output code);
endinterface : tsr_sar_if

// ### design/tsr_sar.sv
// successive approximation register, steps on falling serial clock edges
`include "tsr_map.svh"

module tsr_sar #(
    parameter int W = `TSR_RESULT_BITS
) (
    // link side
    tsr_sar_if.sar sar
);
    import tsr_pkg::*;

    localparam logic [4:0] MSB_FALL = `TSR_MSB_FALL;
    localparam logic [4:0] LSB_FALL = 5'(`TSR_MSB_FALL + W - 1);

    logic [W-1:0] code_next;
    logic [4:0]   bit_idx;

    // bit under decision, counted from the lsb
    assign bit_idx = 5'(LSB_FALL - sar.fall_cnt);

    always_comb begin
        code_next = sar.code;
        for (int i = 0; i < W; i++) begin
            // comparator high means input above trial, so bit stays one
            if (5'(i) == bit_idx) begin
                code_next[i] = sar.cmp_q;
            end
            if (5'(i + 1) == bit_idx) begin
                code_next[i] = 1'b1;
            end
        end
    end

    always_ff @(negedge sar.sclk or posedge sar.rst_cs) begin
        if (sar.rst_cs) begin
            sar.code <= '0;
        end else if (sar.fall_cnt == `TSR_BUSY_FALL) begin
            sar.code <= {1'b1, {(W - 1){1'b0}}};
        end else if (sar.fall_cnt >= MSB_FALL && sar.fall_cnt <= LSB_FALL) begin
            sar.code <= code_next;
        end
    end

endmodule : tsr_sar

// ### tb/tsr_readout_assertions.sv
// concurrent checks on the ports of the touch panel readout
module tsr_readout_assertions #(
    parameter int CMD_BITS = 8,
    parameter int RES_BITS = 12
) (
    // system side
    input logic                i_clk,
    input logic                i_rst,
    // serial link
    input logic                i_serial_clock,
    input logic                i_chip_select_low,
    input logic                o_serial_result_output,
    input logic                o_serial_result_oe_low,
    input logic                o_busy,
    input logic                o_busy_oe_low,
    // converter and panel
    input logic                i_cmp_above,
    input logic [RES_BITS-1:0] o_dac_code,
    input logic                o_track,
    input logic                i_pen_down,
    input tsr_pkg::tsr_plate_t o_x_plus_plate,
    input tsr_pkg::tsr_plate_t o_y_plus_plate,
    input tsr_pkg::tsr_plate_t o_x_minus_plate,
    input tsr_pkg::tsr_plate_t o_y_minus_plate,
    // interrupt, reference and power
    input logic                o_touch_interrupt_low,
    input logic                o_ref_drive,
    input logic                o_power_down
);
    timeunit 1ns;
    timeprecision 100ps;
    import tsr_pkg::*;

    logic [4:0] fall_cnt;
    logic       cmp_prev;

    // falling edges seen in this frame, saturating so long frames cannot wrap
    always_ff @(negedge i_serial_clock or posedge i_chip_select_low) begin
        if (i_chip_select_low) begin
            fall_cnt <= 5'h00;
        end else if (fall_cnt != 5'h1F) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    // comparator as it stood over the previous rising edge
    always_ff @(negedge i_serial_clock) begin
        cmp_prev <= i_cmp_above;
    end

    AST_BUSY_WINDOW: assert property (@(negedge i_serial_clock) disable iff (i_chip_select_low)
        o_busy == (fall_cnt == 5'h08)) else $error("busy outside 8th to 9th fall");
    AST_RESULT_BITS: assert property (@(negedge i_serial_clock) disable iff (i_chip_select_low)
        (fall_cnt >= 5'h09 && fall_cnt <= 5'h14) |-> o_serial_result_output == cmp_prev)
        else $error("result bit differs from comparator");
    AST_MSB_AT_BUSY_FALL: assert property (@(negedge i_serial_clock)
        disable iff (i_chip_select_low) $fell(o_busy) |-> o_serial_result_output == cmp_prev)
        else $error("msb not present at busy fall");
    AST_IDLE_LOW: assert property (@(negedge i_serial_clock) disable iff (i_chip_select_low)
        (fall_cnt <= 5'h08 || fall_cnt >= 5'h15) |-> !o_serial_result_output)
        else $error("result output not low while idle");
    AST_TRIAL_START: assert property (@(negedge i_serial_clock) disable iff (i_chip_select_low)
        fall_cnt == 5'h08 |-> o_dac_code == {1'b1, {(RES_BITS-1){1'b0}}})
        else $error("first trial code wrong");
    AST_TRACK: assert property (@(negedge i_serial_clock) disable iff (i_chip_select_low)
        o_track == (fall_cnt >= 5'h05 && fall_cnt <= 5'h07)) else $error("track window wrong");
    AST_DESEL_HIZ: assert property (@(posedge i_clk) disable iff (i_rst)
        i_chip_select_low [*5] |-> o_serial_result_oe_low && o_busy_oe_low)
        else $error("outputs driven while deselected");
    AST_SEL_DRIVE: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_chip_select_low [*5] |-> !o_busy_oe_low && (o_busy == (fall_cnt == 5'h08)))
        else $error("busy not driven low");
    AST_PEN_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
        i_chip_select_low [*2] |-> o_x_plus_plate == TSR_PLATE_PULLUP
        && o_y_plus_plate == TSR_PLATE_OPEN && o_y_minus_plate == TSR_PLATE_LOW)
        else $error("plates not in pen wait");
    AST_IRQ_PEN_UP: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chip_select_low && !i_pen_down) [*5] |-> o_touch_interrupt_low)
        else $error("interrupt low without pen");
    AST_IRQ_SELECTED: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_chip_select_low [*5] |-> o_touch_interrupt_low) else $error("interrupt low selected");
    AST_POWER_REF: assert property (@(posedge i_clk) disable iff (i_rst)
        o_power_down |-> !o_ref_drive) else $error("reference driven in power down");

    CVR_BUSY: cover property (@(negedge i_serial_clock) $fell(o_busy));
    CVR_IRQ: cover property (@(posedge i_clk) !o_touch_interrupt_low);
    CVR_WAKE: cover property (@(posedge i_clk) $fell(o_power_down));
endmodule : tsr_readout_assertions

bind tsr_readout tsr_readout_assertions #(.CMD_BITS(CMD_BITS), .RES_BITS(RES_BITS)) i_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_serial_clock(i_serial_clock),
    .i_chip_select_low(i_chip_select_low), .o_serial_result_output(o_serial_result_output),
    .o_serial_result_oe_low(o_serial_result_oe_low), .o_busy(o_busy),
    .o_busy_oe_low(o_busy_oe_low), .i_cmp_above(i_cmp_above), .o_dac_code(o_dac_code),
    .o_track(o_track), .i_pen_down(i_pen_down), .o_x_plus_plate(o_x_plus_plate),
    .o_y_plus_plate(o_y_plus_plate), .o_x_minus_plate(o_x_minus_plate),
    .o_y_minus_plate(o_y_minus_plate), .o_touch_interrupt_low(o_touch_interrupt_low),
    .o_ref_drive(o_ref_drive), .o_power_down(o_power_down)
);

// ### tb/tsr_host_model.sv
// host model of the serial link: select, serial clock, command and result capture
module tsr_host_model (
    // serial link
    output logic o_sclk,
    output logic o_cs_low,
    output logic o_cmd,
    input  logic i_dout,
    input  logic i_busy
);
    timeunit 1ns;
    timeprecision 100ps;

    realtime last_start = -8000.0;
    event    mid;

    initial begin
        o_sclk = 1'b0;
        o_cs_low = 1'b0;
        o_cmd = 1'b0;
        // a real rising edge of select resets the link logic, free of a time-zero race
        #1 o_cs_low = 1'b1;
    end

    // one frame; the clock stands still low outside it
    task automatic frame(input logic [7:0] cmd, output logic [11:0] res,
                         output logic [1:0] busy, output logic tail);
        if ($realtime < last_start + 8000.0) begin
            #(last_start + 8000.0 - $realtime);
        end
        last_start = $realtime;
        o_cs_low = 1'b0;
        #120;
        for (int n = 1; n <= 22; n++) begin
            o_cmd = (n <= 8) ? cmd[8-n] : 1'b0;
            #7.5 o_sclk = 1'b1;
            if (n == 9 || n == 10) busy[10-n] = i_busy;
            if (n >= 10 && n <= 21) res[21-n] = i_dout;
            if (n == 22) tail = i_dout;
            if (n == 12) ->mid;
            #7.5 o_sclk = 1'b0;
        end
        #200 o_cs_low = 1'b1;
    endtask : frame

    // clocks and command ones while deselected, which must be ignored
    task automatic noise();
        for (int n = 0; n < 8; n++) begin
            o_cmd = 1'b1;
            #7.5 o_sclk = 1'b1;
            #7.5 o_sclk = 1'b0;
        end
        o_cmd = 1'b0;
    endtask : noise
endmodule : tsr_host_model

// ### tb/tb_touch_panel_serial_readout.sv
// self-checking bench for the touch panel serial readout
`include "tsr_map.svh"

module tb_touch_panel_serial_readout;
    timeunit 1ns;
    timeprecision 100ps;
    import tsr_pkg::*;

    localparam tsr_plate_t OP = TSR_PLATE_OPEN, HI = TSR_PLATE_HIGH;
    localparam tsr_plate_t LO = TSR_PLATE_LOW, SE = TSR_PLATE_SENSE;

    logic        clk, rst, cmp, pen, junk, sclk, cs_low, cmd, dout, dout_oe_low;
    logic        busy, busy_oe_low, track, irq_low, refd, pdn;
    logic [11:0] vin, dac;
    tsr_plate_t  xp, yp, xm, ym;
    logic [11:0] exp_q[$];
    wire         dout_line, busy_line;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    // released lines toggle so that a stale value cannot pass for a result
    assign dout_line = dout_oe_low ? junk : dout;
    assign busy_line = busy_oe_low ? ~junk : busy;
    assign cmp = (vin >= dac);

    tsr_readout i_dut (
        .i_clk(clk), .i_rst(rst), .i_serial_clock(sclk), .i_chip_select_low(cs_low),
        .i_serial_command_input(cmd), .o_serial_result_output(dout),
        .o_serial_result_oe_low(dout_oe_low), .o_busy(busy), .o_busy_oe_low(busy_oe_low),
        .i_cmp_above(cmp), .o_dac_code(dac), .o_track(track), .i_pen_down(pen),
        .o_x_plus_plate(xp), .o_y_plus_plate(yp), .o_x_minus_plate(xm), .o_y_minus_plate(ym),
        .o_touch_interrupt_low(irq_low), .o_ref_drive(refd), .o_power_down(pdn)
    );

    tsr_host_model i_host (
        .o_sclk(sclk), .o_cs_low(cs_low), .o_cmd(cmd), .i_dout(dout_line), .i_busy(busy_line)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        junk <= ~junk;
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check_word(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_word(what, {11'h000, exp}, {11'h000, got});
    endtask : check_bit

    function automatic tsr_panel_t exp_panel(input logic [2:0] ch);
        case (ch)
            `TSR_CH_X_AXIS: return {HI, SE, LO, OP};
            `TSR_CH_Y_AXIS: return {SE, HI, OP, LO};
            `TSR_CH_PRESS_FIRST: return {SE, HI, LO, OP};
            `TSR_CH_PRESS_SECOND: return {OP, HI, LO, SE};
            default: return {OP, OP, OP, OP};
        endcase
    endfunction : exp_panel

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        logic [11:0] res;
        logic [1:0]  bz;
        logic        tail;
        logic [1:0]  pd;
        rst = 1'b1;
        pen = 1'b0;
        vin = 12'h000;
        junk = 1'b0;
        void'($urandom(32'h1F1D));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check_bit("irq after reset", 1'b1, irq_low);
        check_bit("ref after reset", 1'b0, refd);
        check_bit("power down after reset", 1'b1, pdn);
        i_host.noise();
        repeat (8) @(posedge clk);
        #1;
        check_bit("power down after noise", 1'b1, pdn);
        check_bit("result released", 1'b1, dout_oe_low);
        // every channel code once; power bits walk through all four settings
        for (int k = 0; k < 8; k++) begin
            pd = k[1:0];
            vin = (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : 12'($urandom);
            exp_q.push_back(vin);
            pen = k[1] ^ k[2];
            fork
                i_host.frame({1'b0, k[2:0], 2'b00, pd}, res, bz, tail);
                begin
                    @(i_host.mid);
                    check_word("plates", exp_panel(k[2:0]), {xp, yp, xm, ym});
                end
            join
            check_word("result", exp_q.pop_front(), res);
            check_word("busy at rise 9 and 10", 12'h002, {10'h000, bz});
            check_bit("output after lsb", 1'b0, tail);
            repeat (8) @(posedge clk);
            #1;
            check_word("pen wait", {TSR_PLATE_PULLUP, OP, OP, LO}, {xp, yp, xm, ym});
            check_bit("reference drive", pd[1], refd);
            check_bit("power down", pd == 2'b00, pdn);
            check_bit("pen irq", !(pen && !pd[0]), irq_low);
        end
        stop_test();
    end
endmodule : tb_touch_panel_serial_readout
